// ---- pkg/gpio_port_defs.vh ----
// constants for the general purpose pin block
`ifndef GPIO_PORT_DEFS_VH
`define GPIO_PORT_DEFS_VH
`define GPIO_PIN_COUNT 11
`define GPIO_FUNC_RESET 11'h000
`define GPIO_DIR_RESET 11'h000
`define GPIO_DATA_RESET 11'h000
`define GPIO_REG_FUNC 2'h0
`define GPIO_REG_DIR 2'h1
`define GPIO_REG_DATA 2'h2
`define GPIO_SAMPLE_NS 128
`define GPIO_CLK_NS 10
`define GPIO_SAMPLE_CYCLES ((`GPIO_SAMPLE_NS + `GPIO_CLK_NS - 1) / `GPIO_CLK_NS)
`define GPIO_PIN_PORT2_RST 0
`define GPIO_PIN_PORT4_RST 1
`define GPIO_PIN_IRQ0 2
`define GPIO_PIN_IRQ1 3
`define GPIO_PIN_IRQ2 4
`define GPIO_PIN_EVENT 7
`define GPIO_PIN_PORT3_RST 9
`define GPIO_PIN_PORT5_RST 10
`endif

// ---- logic/switch_gpio_port_altfunc.v ----
// general purpose pin block with alternate functions
//
// Contract
// - eleven pins, each configured on its own
// - selector and direction choose input, output, alternate
// - reset gives general input on all pins
// - sample inputs once per 13 clocks (130ns), async tolerant
// - general function forces alternate function inactive
// - general input level registered into data bit
// - data read returns pin level in every mode
// - general output drives data register bit
// - fixed alternate function pin mapping
// - registers only via upstream configuration port
`timescale 1ns/1ps
`default_nettype none
`include "gpio_port_defs.vh"
module switch_gpio_port_altfunc #(
  parameter integer PINS = `GPIO_PIN_COUNT,
  parameter integer SAMPLE_CYCLES = `GPIO_SAMPLE_CYCLES
) (
  input wire clk, // core clock
  input wire nrst, // fundamental reset, sync active low
  input wire cfg_wr, // upstream config space write strobe
  input wire cfg_rd, // upstream config space read strobe
  input wire [1:0] cfg_reg, // register select
  input wire [PINS-1:0] cfg_wdata, // write data
  output reg [PINS-1:0] cfg_rdata, // read data
  output reg cfg_rvalid, // read data valid
  input wire [PINS-1:0] pin_in, // pad input level
  output wire [PINS-1:0] pin_out, // pad output level
  output wire [PINS-1:0] pin_oe, // pad output enable
  input wire port2_reset_n, // core reset request, port 2
  input wire port3_reset_n, // core reset request, port 3
  input wire port4_reset_n, // core reset request, port 4
  input wire port5_reset_n, // core reset request, port 5
  input wire general_event, // core event request, active high
  output wire expander_irq0_n, // expander interrupt 0 to core
  output wire expander_irq1_n, // expander interrupt 1 to core
  output wire expander_irq2_n // expander interrupt 2 to core
);
  reg [PINS-1:0] pin_function_select;
  reg [PINS-1:0] pin_direction_config;
  reg [PINS-1:0] out_latch;
  reg [PINS-1:0] sync_a;
  reg [PINS-1:0] sync_b;
  reg [PINS-1:0] pin_data_value;
  // counter is 8 bits wide, so the interval is cut to that width on purpose
  localparam integer TICK_LAST_I = SAMPLE_CYCLES - 1;
  localparam [7:0] TICK_LAST = TICK_LAST_I[7:0];
  reg [7:0] tick_cnt;
  wire tick;
  wire [PINS-1:0] gp_out;
  reg [PINS-1:0] alt_out;
  reg [PINS-1:0] alt_oe;

  // only the upstream config port reaches these registers
  always @(posedge clk) begin
    if (!nrst) begin
      pin_function_select <= `GPIO_FUNC_RESET;
      pin_direction_config <= `GPIO_DIR_RESET;
      out_latch <= `GPIO_DATA_RESET;
    end else if (cfg_wr) begin
      case (cfg_reg)
        `GPIO_REG_FUNC: pin_function_select <= cfg_wdata;
        `GPIO_REG_DIR: pin_direction_config <= cfg_wdata;
        `GPIO_REG_DATA: out_latch <= cfg_wdata;
        default: out_latch <= out_latch;
      endcase
    end
  end

  // sample strobe; inputs need not settle faster than this
  assign tick = (tick_cnt == TICK_LAST);
  always @(posedge clk) begin
    if (!nrst || tick)
      tick_cnt <= 8'h00;
    else
      tick_cnt <= tick_cnt + 8'h01;
  end

  // first stage is read only by the second
  always @(posedge clk) begin
    if (!nrst) begin
      sync_a <= {PINS{1'b0}};
      sync_b <= {PINS{1'b0}};
      pin_data_value <= `GPIO_DATA_RESET;
    end else begin
      sync_a <= pin_in;
      sync_b <= sync_a;
      if (tick)
        pin_data_value <= sync_b;
    end
  end

  // inactive levels: resets high, event low
  always @* begin
    alt_out = {PINS{1'b0}};
    alt_oe = {PINS{1'b0}};
    alt_out[`GPIO_PIN_PORT2_RST] = port2_reset_n;
    alt_out[`GPIO_PIN_PORT4_RST] = port4_reset_n;
    alt_out[`GPIO_PIN_PORT3_RST] = port3_reset_n;
    alt_out[`GPIO_PIN_PORT5_RST] = port5_reset_n;
    alt_out[`GPIO_PIN_EVENT] = general_event;
    alt_oe[`GPIO_PIN_PORT2_RST] = 1'b1;
    alt_oe[`GPIO_PIN_PORT4_RST] = 1'b1;
    alt_oe[`GPIO_PIN_PORT3_RST] = 1'b1;
    alt_oe[`GPIO_PIN_PORT5_RST] = 1'b1;
    alt_oe[`GPIO_PIN_EVENT] = 1'b1;
  end

  genvar i;
  generate
    for (i = 0; i < PINS; i = i + 1) begin : g_pin
      assign gp_out[i] = out_latch[i];
      assign pin_out[i] = pin_function_select[i] ? alt_out[i] : gp_out[i];
      assign pin_oe[i] = pin_function_select[i] ? alt_oe[i] : pin_direction_config[i];
    end
  endgenerate

  // interrupts read inactive (high) unless the pin carries them
  assign expander_irq0_n = pin_function_select[`GPIO_PIN_IRQ0] ? pin_data_value[`GPIO_PIN_IRQ0] : 1'b1;
  assign expander_irq1_n = pin_function_select[`GPIO_PIN_IRQ1] ? pin_data_value[`GPIO_PIN_IRQ1] : 1'b1;
  assign expander_irq2_n = pin_function_select[`GPIO_PIN_IRQ2] ? pin_data_value[`GPIO_PIN_IRQ2] : 1'b1;

  always @(posedge clk) begin
    if (!nrst) begin
      cfg_rdata <= {PINS{1'b0}};
      cfg_rvalid <= 1'b0;
    end else begin
      cfg_rvalid <= cfg_rd;
      if (cfg_rd) begin
        case (cfg_reg)
          `GPIO_REG_FUNC: cfg_rdata <= pin_function_select;
          `GPIO_REG_DIR: cfg_rdata <= pin_direction_config;
          `GPIO_REG_DATA: cfg_rdata <= pin_data_value;
          default: cfg_rdata <= {PINS{1'b0}};
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ---- verif/gpio_port_props.sv ----
// port checks for the pin block
`timescale 1ns/1ps
`default_nettype none
module gpio_port_props #(parameter integer PINS = 11) (
  input wire clk, nrst, cfg_wr, cfg_rd, cfg_rvalid, general_event, expander_irq0_n, // control
  input wire port2_reset_n, port3_reset_n, port4_reset_n, port5_reset_n, // core resets
  input wire [1:0] cfg_reg, // select
  input wire [PINS-1:0] cfg_wdata, cfg_rdata, pin_out, pin_oe // data, pads
);
  reg [PINS-1:0] f, d, o;
  wire [10:0] av = {port5_reset_n, port3_reset_n, 1'b0, general_event, 5'h00, port4_reset_n, port2_reset_n};
  always @(posedge clk) begin
    if (!nrst) {f, d, o} <= 0;
    else if (cfg_wr) case (cfg_reg) 2'h0: f <= cfg_wdata; 2'h1: d <= cfg_wdata; 2'h2: o <= cfg_wdata; endcase
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_read_answer: assert property (cfg_rd |=> cfg_rvalid) else $error("no answer");
  a_valid_pulse: assert property (!cfg_rd |=> !cfg_rvalid) else $error("stray valid");
  a_unmapped_zero: assert property (cfg_rd && cfg_reg == 2'h3 |=> cfg_rdata == 0) else $error("unmapped");
  a_reset_input: assert property ($rose(nrst) |-> pin_oe == 0 && expander_irq0_n) else $error("reset");
  a_mode_enable: assert property (pin_oe == (~f & d | f & 11'h683)) else $error("enable");
  a_output_value: assert property (((pin_out ^ o) & ~f & d) == 0) else $error("drive");
  a_alt_map: assert property (((pin_out ^ av) & f & 11'h683) == 0) else $error("alt map");
  a_irq_idle: assert property (!f[2] |-> expander_irq0_n) else $error("irq");
  cover property (cfg_rd && cfg_reg == 2'h2);
  cover property (|(f & pin_oe));
  cover property (f[2] && !expander_irq0_n);
endmodule
`default_nettype wire

// ---- verif/gpio_pad_model.sv ----
// outside circuitry: a driven pad reads its drive, else the outside level
`timescale 1ns/1ps
`default_nettype none
module gpio_pad_model (input wire [10:0] pin_out, pin_oe, ext, output wire [10:0] pin_in);
  // unclocked on purpose, the drive is only a level
  assign #2 pin_in = pin_oe & pin_out | ~pin_oe & ext;
endmodule
`default_nettype wire

// ---- verif/switch_gpio_port_altfunc_tb.sv ----
// bench for the pin block
`timescale 1ns/1ps
`default_nettype none
module switch_gpio_port_altfunc_tb;
  reg clk = 0, nrst = 0, cfg_wr = 0, cfg_rd = 0, general_event = 0;
  reg port2_reset_n = 1, port3_reset_n = 1, port4_reset_n = 1, port5_reset_n = 1;
  reg [1:0] cfg_reg = 0;
  reg [10:0] cfg_wdata = 0, ext = 0;
  wire [10:0] cfg_rdata, pin_out, pin_oe, pin_in;
  wire cfg_rvalid, expander_irq0_n, expander_irq1_n, expander_irq2_n;
  integer bad_count = 0, samples_checked = 0, cyc = 0;
  switch_gpio_port_altfunc u_dut (.clk(clk), .nrst(nrst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_reg(cfg_reg),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .port2_reset_n(port2_reset_n), .port3_reset_n(port3_reset_n), .port4_reset_n(port4_reset_n),
    .port5_reset_n(port5_reset_n), .general_event(general_event), .expander_irq0_n(expander_irq0_n),
    .expander_irq1_n(expander_irq1_n), .expander_irq2_n(expander_irq2_n));
  gpio_pad_model u_pad (.pin_out(pin_out), .pin_oe(pin_oe), .ext(ext), .pin_in(pin_in));
  initial forever #5 clk = ~clk;
  task chk(input [10:0] s, input [10:0] e); begin
    samples_checked = samples_checked + 1;
    if (s !== e) begin
      bad_count = bad_count + 1;
      $display("FAIL %0t %h %h", $time, s, e);
    end
  end endtask
  task acc(input w, input [1:0] r, input [10:0] v); begin
    @(posedge clk) #1 {cfg_wr, cfg_rd, cfg_reg, cfg_wdata} = {w, !w, r, v};
    @(posedge clk) #1 {cfg_wr, cfg_rd} = 2'h0;
  end endtask
  task rdc(input [1:0] r, input [10:0] e); begin
    acc(1'b0, r, 11'h000);
    chk(cfg_rvalid, 11'h001);
    chk(cfg_rdata, e);
  end endtask
  task end_of_test; begin
    $display("compares %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  end endtask
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 2000) begin
      bad_count = bad_count + 1;
      end_of_test;
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    #1 nrst = 1;
    chk(pin_oe, 11'h000);
    rdc(2'h0, 11'h000);
    rdc(2'h1, 11'h000);
    ext = 11'h555;
    rdc(2'h2, 11'h000);
    acc(1'b1, 2'h2, 11'h7FF);
    repeat (15) @(posedge clk);
    rdc(2'h2, 11'h555);
    acc(1'b1, 2'h1, 11'h7FF);
    acc(1'b1, 2'h2, 11'h0AA);
    chk(pin_out & pin_oe, 11'h0AA);
    repeat (16) @(posedge clk);
    rdc(2'h2, 11'h0AA);
    {port2_reset_n, port3_reset_n, port4_reset_n, port5_reset_n, general_event, ext} = {5'h0B, 11'h7EB};
    acc(1'b1, 2'h0, 11'h7FF);
    acc(1'b1, 2'h3, 11'h000);
    repeat (16) @(posedge clk);
    chk({expander_irq2_n, expander_irq1_n, expander_irq0_n}, 11'h002);
    rdc(2'h2, 11'h7E8);
    rdc(2'h0, 11'h7FF);
    rdc(2'h3, 11'h000);
    acc(1'b1, 2'h0, 11'h000);
    chk({expander_irq2_n, expander_irq1_n, expander_irq0_n}, 11'h007);
    end_of_test;
  end
endmodule
bind switch_gpio_port_altfunc gpio_port_props #(.PINS(PINS)) u_props (.clk(clk), .nrst(nrst), .cfg_wr(cfg_wr),
  .cfg_rd(cfg_rd), .cfg_rvalid(cfg_rvalid), .general_event(general_event), .expander_irq0_n(expander_irq0_n),
  .port2_reset_n(port2_reset_n), .port3_reset_n(port3_reset_n), .port4_reset_n(port4_reset_n),
  .port5_reset_n(port5_reset_n), .cfg_reg(cfg_reg), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
  .pin_out(pin_out), .pin_oe(pin_oe));
`default_nettype wire
